// ### core/vwar_pkg.sv
// constants shared by the vsync and window address register block
package vwar_pkg;

  // bus geometry: each byte register sits in one aligned 32-bit word
  localparam int          ADDR_BITS  = 8;
  localparam int          IDX_BITS   = 6;
  localparam int          DATA_BITS  = 32;

  // register indices; byte address is four times the index
  localparam logic [5:0]  IDX_MAIN_CONFIG   = 6'h10;
  localparam logic [5:0]  IDX_VFP           = 6'h1E;
  localparam logic [5:0]  IDX_VPW           = 6'h1F;
  localparam logic [5:0]  IDX_MAIN_ADDR_0   = 6'h20;
  localparam logic [5:0]  IDX_MAIN_ADDR_1   = 6'h21;
  localparam logic [5:0]  IDX_MAIN_ADDR_2   = 6'h22;
  localparam logic [5:0]  IDX_MAIN_ADDR_3   = 6'h23;
  localparam logic [5:0]  IDX_MAIN_WIDTH_LO = 6'h24;
  localparam logic [5:0]  IDX_MAIN_WIDTH_HI = 6'h25;
  localparam logic [5:0]  IDX_MAIN_X_LO     = 6'h26;
  localparam logic [5:0]  IDX_MAIN_X_HI     = 6'h27;
  localparam logic [5:0]  IDX_MAIN_Y_LO     = 6'h28;
  localparam logic [5:0]  IDX_MAIN_Y_HI     = 6'h29;
  localparam logic [5:0]  IDX_INSET_X_LO    = 6'h2A;
  localparam logic [5:0]  IDX_INSET_X_HI    = 6'h2B;
  localparam logic [5:0]  IDX_INSET_Y_LO    = 6'h2C;
  localparam logic [5:0]  IDX_INSET_Y_HI    = 6'h2D;
  localparam logic [5:0]  IDX_INSET_ADDR_0  = 6'h2E;
  localparam logic [5:0]  IDX_INSET_ADDR_1  = 6'h2F;
  localparam logic [5:0]  IDX_INSET_ADDR_2  = 6'h30;
  localparam logic [5:0]  IDX_INSET_ADDR_3  = 6'h31;

  // staging bytes cover every index from the main address to the inset one
  localparam logic [5:0]  STAGE_BASE  = IDX_MAIN_ADDR_0;
  localparam int          STAGE_DEPTH = 18;

  // field layout
  localparam int          VPW_BITS      = 6;
  localparam int          COORD_BITS    = 13;
  localparam int          HI_BITS       = 5;
  localparam int          ALIGN_BITS    = 2;
  localparam int          INSET_SEL_BIT = 4;
  localparam int          INSET_COUNT   = 2;

  // reset values
  localparam logic [7:0]  VFP_RESET  = 8'h0B;
  localparam logic [5:0]  VPW_RESET  = 6'h00;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [12:0] COORD_RESET = 13'h0000;

  // bus responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // vertical sync sequencer states
  typedef enum logic [1:0] {
    VS_IDLE,
    VS_PORCH,
    VS_PULSE
  } vwar_vs_state_type;

endpackage : vwar_pkg

// ### core/vwar_vsync_gen.sv
// vertical sync sequencer: front porch then pulse, counted in lines
`timescale 1ns/1ps
module vwar_vsync_gen (
  input  wire logic       clock,        // system clock
  input  wire logic       nrst,         // async reset, active low
  input  wire logic       line_tick,    // one pulse per line end
  input  wire logic       display_end,  // pulse after last active line
  input  wire logic [7:0] front_porch,  // porch value, lines minus one
  input  wire logic [5:0] pulse_width,  // pulse value, lines minus one
  output logic            vsync         // sync level, active high
);
  import vwar_pkg::*;

  vwar_vs_state_type state_reg;
  logic [7:0]        line_cnt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // state, line counter and sync output
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg    <= VS_IDLE;
      line_cnt_reg <= 8'h00;
      vsync        <= 1'b0;
    end else if (display_end) begin
      state_reg    <= VS_PORCH;    // restart on every frame end
      line_cnt_reg <= 8'h00;
      vsync        <= 1'b0;
    end else if (line_tick) begin
      case (state_reg)
        VS_PORCH: begin
          if (line_cnt_reg == front_porch) begin
            state_reg    <= VS_PULSE;
            line_cnt_reg <= 8'h00;
            vsync        <= 1'b1;
          end else begin
            line_cnt_reg <= line_cnt_reg + 8'h01;
          end
        end
        VS_PULSE: begin
          if (line_cnt_reg == {2'b00, pulse_width}) begin
            state_reg    <= VS_IDLE;
            line_cnt_reg <= 8'h00;
            vsync        <= 1'b0;
          end else begin
            line_cnt_reg <= line_cnt_reg + 8'h01;
          end
        end
        VS_IDLE: begin
          line_cnt_reg <= 8'h00;
        end
        default: begin
          state_reg    <= VS_IDLE;
          line_cnt_reg <= 8'h00;
          vsync        <= 1'b0;
        end
      endcase
    end
  end

endmodule : vwar_vsync_gen

// ### core/vwar_regs.sv
// vsync and window address registers with axi4-lite slave
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
module vwar_regs (
  input  wire logic        clock,               // system clock, 10 MHz
  input  wire logic        nrst,                // async reset, active low
  // axi4-lite slave
  input  wire logic [vwar_pkg::ADDR_BITS-1:0] s_axi_awaddr,  // write addr
  input  wire logic        s_axi_awvalid,       // write addr valid
  output logic             s_axi_awready,       // write addr ready
  input  wire logic [31:0] s_axi_wdata,         // write data
  input  wire logic [3:0]  s_axi_wstrb,         // write byte strobes
  input  wire logic        s_axi_wvalid,        // write data valid
  output logic             s_axi_wready,        // write data ready
  output logic [1:0]       s_axi_bresp,         // write response
  output logic             s_axi_bvalid,        // write response valid
  input  wire logic        s_axi_bready,        // write response ready
  input  wire logic [vwar_pkg::ADDR_BITS-1:0] s_axi_araddr,  // read addr
  input  wire logic        s_axi_arvalid,       // read addr valid
  output logic             s_axi_arready,       // read addr ready
  output logic [31:0]      s_axi_rdata,         // read data
  output logic [1:0]       s_axi_rresp,         // read response
  output logic             s_axi_rvalid,        // read data valid
  input  wire logic        s_axi_rready,        // read data ready
  // panel timing
  input  wire logic        line_tick,           // one pulse per line end
  input  wire logic        display_end,         // pulse after active area
  output logic             vsync,               // vertical sync, high
  // working values for the fetch logic
  output logic [31:0]      main_start_address,  // main image address
  output logic [12:0]      main_image_width,    // main image width
  output logic [12:0]      main_window_left_x,  // main window x
  output logic [12:0]      main_window_top_y,   // main window y
  output logic             inset_select,        // window being configured
  output logic [12:0]      inset1_left_x,       // inset window 1 x
  output logic [12:0]      inset1_top_y,        // inset window 1 y
  output logic [31:0]      inset1_start_address,// inset window 1 address
  output logic [12:0]      inset2_left_x,       // inset window 2 x
  output logic [12:0]      inset2_top_y,        // inset window 2 y
  output logic [31:0]      inset2_start_address // inset window 2 address
);
  import vwar_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // storage

  logic [ADDR_BITS-1:0] aw_addr_reg;
  logic [7:0]           w_byte_reg;
  logic                 w_lane0_reg;
  logic [7:0]           vfp_reg;
  logic [VPW_BITS-1:0]  vpw_reg;
  logic [7:0]           stage_reg [STAGE_DEPTH];
  logic [12:0]          inset_x_reg [INSET_COUNT];
  logic [12:0]          inset_y_reg [INSET_COUNT];
  logic [31:0]          inset_addr_reg [INSET_COUNT];

  logic                 wr_fire;
  logic                 wr_en;
  logic [IDX_BITS-1:0]  wr_idx;
  logic [7:0]           wr_byte;
  logic [IDX_BITS-1:0]  rd_idx;
  logic [7:0]           rd_byte;
  logic                 rd_hit;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // true for every index that holds a register
  function automatic logic is_mapped(input logic [IDX_BITS-1:0] idx);
    is_mapped = (idx == IDX_MAIN_CONFIG) || (idx == IDX_VFP) ||
                (idx == IDX_VPW) ||
                ((idx >= IDX_MAIN_ADDR_0) && (idx <= IDX_INSET_ADDR_3));
  endfunction : is_mapped

  // staged byte belonging to a register index
  function automatic logic [7:0] staged(input logic [IDX_BITS-1:0] idx);
    logic [IDX_BITS-1:0] pos;
    pos    = idx - STAGE_BASE;
    staged = stage_reg[pos[4:0]];
  endfunction : staged

  // staged byte with its alignment bits cleared
  function automatic logic [7:0] aligned(input logic [IDX_BITS-1:0] idx);
    aligned                 = staged(idx);
    aligned[ALIGN_BITS-1:0] = '0;
  endfunction : aligned

  ////////////////////////////////////////////////////////////////////////////
  // write channels: address and data taken in either order

  // write happens once both halves are held and no response is pending
  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_idx  = aw_addr_reg[ADDR_BITS-1:2];
  assign wr_byte = w_byte_reg;
  assign wr_en   = wr_fire && w_lane0_reg;  // only lane 0 carries a byte

  // write address channel
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_axi_awready <= 1'b1;
      aw_addr_reg   <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_addr_reg   <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  // write data channel
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_axi_wready <= 1'b1;
      w_byte_reg   <= 8'h00;
      w_lane0_reg  <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_byte_reg   <= s_axi_wdata[7:0];
      w_lane0_reg  <= s_axi_wstrb[0];
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // write response, error for an unmapped index
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= is_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // single-byte registers, applied at once

  // vertical front porch
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      vfp_reg <= VFP_RESET;
    end else if (wr_en && (wr_idx == IDX_VFP)) begin
      vfp_reg <= wr_byte;
    end
  end

  // vertical pulse width, upper two bits dropped
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      vpw_reg <= VPW_RESET;
    end else if (wr_en && (wr_idx == IDX_VPW)) begin
      vpw_reg <= wr_byte[VPW_BITS-1:0];
    end
  end

  // inset window select, all other bits ignored
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      inset_select <= 1'b0;
    end else if (wr_en && (wr_idx == IDX_MAIN_CONFIG)) begin
      inset_select <= wr_byte[INSET_SEL_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // staging bytes for multi-byte values

  // every byte lands here; only the highest byte moves the value on
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < STAGE_DEPTH; i++) begin
        stage_reg[i] <= 8'h00;
      end
    end else if (wr_en && (wr_idx >= IDX_MAIN_ADDR_0) &&
                 (wr_idx <= IDX_INSET_ADDR_3)) begin
      stage_reg[5'(wr_idx - STAGE_BASE)] <= wr_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // main image working registers

  // start address, committed on the top byte, alignment bits forced low
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      main_start_address <= ADDR_RESET;
    end else if (wr_en && (wr_idx == IDX_MAIN_ADDR_3)) begin
      main_start_address <= {wr_byte, staged(IDX_MAIN_ADDR_2),
                             staged(IDX_MAIN_ADDR_1),
                             aligned(IDX_MAIN_ADDR_0)};
    end
  end

  // image width, 13 bits, unused upper bits dropped
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      main_image_width <= COORD_RESET;
    end else if (wr_en && (wr_idx == IDX_MAIN_WIDTH_HI)) begin
      main_image_width <= {wr_byte[HI_BITS-1:0],
                           aligned(IDX_MAIN_WIDTH_LO)};
    end
  end

  // window left x, kept aligned
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      main_window_left_x <= COORD_RESET;
    end else if (wr_en && (wr_idx == IDX_MAIN_X_HI)) begin
      main_window_left_x <= {wr_byte[HI_BITS-1:0],
                             aligned(IDX_MAIN_X_LO)};
    end
  end

  // window top y, any value, no alignment
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      main_window_top_y <= COORD_RESET;
    end else if (wr_en && (wr_idx == IDX_MAIN_Y_HI)) begin
      main_window_top_y <= {wr_byte[HI_BITS-1:0],
                            staged(IDX_MAIN_Y_LO)};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // inset window working registers, one set per window

  // left x of the selected window
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < INSET_COUNT; i++) begin
        inset_x_reg[i] <= COORD_RESET;
      end
    end else if (wr_en && (wr_idx == IDX_INSET_X_HI)) begin
      inset_x_reg[inset_select] <= {wr_byte[HI_BITS-1:0],
                                    aligned(IDX_INSET_X_LO)};
    end
  end

  // top y of the selected window, host keeps it inside the display
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < INSET_COUNT; i++) begin
        inset_y_reg[i] <= COORD_RESET;
      end
    end else if (wr_en && (wr_idx == IDX_INSET_Y_HI)) begin
      inset_y_reg[inset_select] <= {wr_byte[HI_BITS-1:0],
                                    staged(IDX_INSET_Y_LO)};
    end
  end

  // image start address of the selected window
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < INSET_COUNT; i++) begin
        inset_addr_reg[i] <= ADDR_RESET;
      end
    end else if (wr_en && (wr_idx == IDX_INSET_ADDR_3)) begin
      inset_addr_reg[inset_select] <= {wr_byte,
                                       staged(IDX_INSET_ADDR_2),
                                       staged(IDX_INSET_ADDR_1),
                                       aligned(IDX_INSET_ADDR_0)};
    end
  end

  // inset values leave straight from their flip-flops
  assign inset1_left_x        = inset_x_reg[0];
  assign inset1_top_y         = inset_y_reg[0];
  assign inset1_start_address = inset_addr_reg[0];
  assign inset2_left_x        = inset_x_reg[1];
  assign inset2_top_y         = inset_y_reg[1];
  assign inset2_start_address = inset_addr_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // read path: committed values, inset bytes from the selected window

  assign rd_idx = s_axi_araddr[ADDR_BITS-1:2];
  assign rd_hit = is_mapped(rd_idx);

  // byte for a read index, unused bits zero
  always_comb begin
    rd_byte = 8'h00;
    case (rd_idx)
      IDX_MAIN_CONFIG:   rd_byte[INSET_SEL_BIT] = inset_select;
      IDX_VFP:           rd_byte = vfp_reg;
      IDX_VPW:           rd_byte = {2'b00, vpw_reg};
      IDX_MAIN_ADDR_0:   rd_byte = main_start_address[7:0];
      IDX_MAIN_ADDR_1:   rd_byte = main_start_address[15:8];
      IDX_MAIN_ADDR_2:   rd_byte = main_start_address[23:16];
      IDX_MAIN_ADDR_3:   rd_byte = main_start_address[31:24];
      IDX_MAIN_WIDTH_LO: rd_byte = main_image_width[7:0];
      IDX_MAIN_WIDTH_HI: rd_byte = {3'b000, main_image_width[12:8]};
      IDX_MAIN_X_LO:     rd_byte = main_window_left_x[7:0];
      IDX_MAIN_X_HI:     rd_byte = {3'b000, main_window_left_x[12:8]};
      IDX_MAIN_Y_LO:     rd_byte = main_window_top_y[7:0];
      IDX_MAIN_Y_HI:     rd_byte = {3'b000, main_window_top_y[12:8]};
      IDX_INSET_X_LO:    rd_byte = inset_x_reg[inset_select][7:0];
      IDX_INSET_X_HI:    rd_byte = {3'b000,
                                    inset_x_reg[inset_select][12:8]};
      IDX_INSET_Y_LO:    rd_byte = inset_y_reg[inset_select][7:0];
      IDX_INSET_Y_HI:    rd_byte = {3'b000,
                                    inset_y_reg[inset_select][12:8]};
      IDX_INSET_ADDR_0:  rd_byte = inset_addr_reg[inset_select][7:0];
      IDX_INSET_ADDR_1:  rd_byte = inset_addr_reg[inset_select][15:8];
      IDX_INSET_ADDR_2:  rd_byte = inset_addr_reg[inset_select][23:16];
      IDX_INSET_ADDR_3:  rd_byte = inset_addr_reg[inset_select][31:24];
      default:           rd_byte = 8'h00;
    endcase
  end

  // read address and data channels
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h00_0000, rd_byte};
      s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // vertical sync sequencer driven by the live timing values

  vwar_vsync_gen u_vsync_gen (
    .clock       (clock),
    .nrst        (nrst),
    .line_tick   (line_tick),
    .display_end (display_end),
    .front_porch (vfp_reg),
    .pulse_width (vpw_reg),
    .vsync       (vsync)
  );

endmodule : vwar_regs

// ### tb/vwar_panel_model.sv
// panel timing source: frame end marker then evenly spaced line ticks
`timescale 1ns/1ps
module vwar_panel_model #(
  parameter int LINE_LEN = 3,  // clocks per line
  parameter int LINES    = 8   // lines per blanking run
) (
  input  wire logic clock,       // system clock
  input  wire logic nrst,        // reset, active low
  input  wire logic frame_go,    // start a blanking run
  output logic      line_tick,   // line end pulse
  output logic      display_end  // active area end pulse
);
  int cyc;
  int left;
  // marker first, then one tick every line until the run is spent
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cyc         <= 0;
      left        <= 0;
      line_tick   <= 1'b0;
      display_end <= 1'b0;
    end else begin
      display_end <= frame_go;
      line_tick   <= 1'b0;
      if (frame_go) begin
        cyc  <= 0;
        left <= LINES;
      end else if (left > 0) begin
        cyc <= (cyc == LINE_LEN - 1) ? 0 : cyc + 1;
        if (cyc == LINE_LEN - 1) begin
          left      <= left - 1;
          line_tick <= 1'b1;
        end
      end
    end
  end
endmodule : vwar_panel_model

// ### tb/vwar_regs_properties.sv
// bus timing, vsync placement and commit checks on the register block
`timescale 1ns/1ps
module vwar_regs_properties (
  input wire logic        clock,                 // clock
  input wire logic        nrst,                  // reset
  input wire logic        s_axi_awvalid,         // aw valid
  input wire logic        s_axi_awready,         // aw ready
  input wire logic        s_axi_wvalid,          // w valid
  input wire logic        s_axi_wready,          // w ready
  input wire logic        s_axi_bvalid,          // b valid
  input wire logic        s_axi_arvalid,         // ar valid
  input wire logic        s_axi_arready,         // ar ready
  input wire logic        s_axi_rvalid,          // r valid
  input wire logic        s_axi_rready,          // r ready
  input wire logic [31:0] s_axi_rdata,           // read data
  input wire logic        line_tick,             // line end
  input wire logic        display_end,           // frame end
  input wire logic        vsync,                 // sync out
  input wire logic [31:0] main_start_address,    // main address
  input wire logic [12:0] main_image_width,      // main width
  input wire logic        inset_select,          // inset window
  input wire logic [31:0] inset2_start_address   // inset 2 address
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  property p_wr_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("bvalid timing");
  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("rvalid timing");
  property p_r_done;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
  endproperty
  a_r_done: assert property (p_r_done) else $error("read not closed");
  property p_rd_hi;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("upper bits set");
  property p_align;
    (main_start_address[1:0] | main_image_width[1:0]
      | inset2_start_address[1:0]) == 2'h0;
  endproperty
  a_align: assert property (p_align) else $error("low bits set");
  property p_vs_rise;
    $rose(vsync) |-> $past(line_tick) && !$past(display_end);
  endproperty
  a_vs_rise: assert property (p_vs_rise) else $error("bad vsync rise");
  property p_vs_clr;
    display_end |=> !vsync;
  endproperty
  a_vs_clr: assert property (p_vs_clr) else $error("vsync not reset");
  property p_commit;
    !$stable(main_start_address) |-> $rose(s_axi_bvalid);
  endproperty
  a_commit: assert property (p_commit) else $error("stray commit");
  property p_inset_sel;
    !$stable(inset2_start_address) |-> $past(inset_select);
  endproperty
  a_inset_sel: assert property (p_inset_sel) else $error("wrong inset");
endmodule : vwar_regs_properties
bind vwar_regs vwar_regs_properties i_props (.clock, .nrst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .line_tick,
  .display_end, .vsync, .main_start_address, .main_image_width, .inset_select,
  .inset2_start_address);

// ### tb/tb_top.sv
// self-checking bench for the vsync and window address registers
`timescale 1ns/1ps
module tb_top;
  import vwar_pkg::*;
  `define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_errors++; \
    $display("CHECK FAILED %0t got %h exp %h", $time, a, e); end end
  logic        clock = 1'b0, nrst = 1'b0, frame_go = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, rd_data;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b1, vs_d = 1'b0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, wr_resp, rd_resp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, line_tick, display_end, vsync, inset_select;
  logic [31:0] s_axi_rdata, main_start_address, inset1_start_address;
  logic [31:0] inset2_start_address;
  logic [12:0] main_image_width, main_window_left_x, main_window_top_y;
  logic [12:0] inset1_left_x, inset1_top_y, inset2_left_x, inset2_top_y;
  int          n_errors = 0, tests_run = 0, tk = 0, up_tk = 0, dn_tk = 0;
  always #50 clock = ~clock;
  vwar_regs i_dut (.clock, .nrst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .line_tick, .display_end, .vsync, .main_start_address, .main_image_width,
    .main_window_left_x, .main_window_top_y, .inset_select, .inset1_left_x,
    .inset1_top_y, .inset1_start_address, .inset2_left_x, .inset2_top_y,
    .inset2_start_address);
  vwar_panel_model i_panel (.clock, .nrst, .frame_go, .line_tick,
    .display_end);
  // line count at which vsync rose and fell
  always @(posedge clock) begin
    vs_d <= vsync;
    tk <= display_end ? 0 : (line_tick ? tk + 1 : tk);
    if (vsync && !vs_d) up_tk <= tk;
    if (!vsync && vs_d) dn_tk <= tk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one bus write: address and data offered together, bready always high
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    s_axi_awaddr  <= {i, 2'h0};
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    forever begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    wr_resp = s_axi_bresp;
  endtask : wr
  // writes n bytes of v, lowest byte first
  task automatic wn(input logic [5:0] i, input logic [31:0] v, input int n);
    for (int b = 0; b < n; b++) wr(i + 6'(b), v[8*b +: 8]);
  endtask : wn
  // one bus read, data taken at the edge where rvalid is seen
  task automatic rd(input logic [5:0] i);
    s_axi_araddr  <= {i, 2'h0};
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
  endtask : rd
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_vsync;
    rd(IDX_VFP);
    `CHK(rd_data, 32'h0B)
    wr(IDX_VPW, 8'hC1);
    rd(IDX_VPW);
    `CHK(rd_data, 32'h01)
    wr(IDX_VFP, 8'h02);
    frame_go <= 1'b1;
    @(posedge clock);
    frame_go <= 1'b0;
    repeat (40) @(posedge clock);
    `CHK(up_tk, 3)
    `CHK(dn_tk, 5)
  endtask : t_vsync
  // main address commits only on its top byte
  task automatic t_main;
    wn(IDX_MAIN_ADDR_0, 32'h00BC9A57, 3);
    `CHK(main_start_address, 32'h0)
    wr(IDX_MAIN_ADDR_3, 8'hDE);
    `CHK(main_start_address, 32'hDEBC9A54)
    rd(IDX_MAIN_ADDR_0);
    `CHK(rd_data, 32'h54)
    wn(IDX_MAIN_WIDTH_LO, 32'hFFFF, 2);
    `CHK(main_image_width, 13'h1FFC)
    rd(IDX_MAIN_WIDTH_HI);
    `CHK(rd_data, 32'h1F)
    wn(IDX_MAIN_X_LO, 32'h0104, 2);
    `CHK(main_window_left_x, 13'h0104)
    wn(IDX_MAIN_Y_LO, 32'hFFFF, 2);
    `CHK(main_window_top_y, 13'h1FFF)
  endtask : t_main
  // inset settings steered by the select bit
  task automatic t_inset;
    wn(IDX_INSET_X_LO, 32'h0208, 2);
    wn(IDX_INSET_Y_LO, 32'h0010, 2);
    `CHK(inset1_left_x, 13'h0208)
    `CHK(inset1_top_y, 13'h0010)
    wr(IDX_MAIN_CONFIG, 8'hFF);
    rd(IDX_MAIN_CONFIG);
    `CHK(rd_data, 32'h10)
    wn(IDX_INSET_ADDR_0, 32'h44332213, 4);
    `CHK(inset2_start_address, 32'h44332210)
    `CHK(inset1_start_address, 32'h0)
    rd(IDX_INSET_X_LO);
    `CHK(rd_data, 32'h0)
    wn(IDX_INSET_X_LO, 32'h0A0D, 2);
    wn(IDX_INSET_Y_LO, 32'h0103, 2);
    `CHK(inset2_left_x, 13'h0A0C)
    `CHK(inset2_top_y, 13'h0103)
    `CHK(inset1_left_x, 13'h0208)
  endtask : t_inset
  // unmapped word refused with no data
  task automatic t_unmapped;
    wr(6'h3F, 8'h5A);
    `CHK(wr_resp, RESP_SLVERR)
    rd(6'h3F);
    `CHK(rd_data, 32'h0)
    `CHK(rd_resp, RESP_SLVERR)
    s_axi_wstrb <= 4'h0;
    wr(IDX_VFP, 8'h77);
    s_axi_wstrb <= 4'hF;
    rd(IDX_VFP);
    `CHK(rd_data, 32'h02)
  endtask : t_unmapped
  task tally_and_finish;
    if (n_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  // main sequence
  initial begin
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    t_vsync();
    t_main();
    t_inset();
    t_unmapped();
    tally_and_finish();
  end
  // watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge clock);
    n_errors++;
    tally_and_finish();
  end
endmodule : tb_top
